// *** core/shp_device.sv ***
`timescale 1ns/1ps
// Contract
// - Host access only while chip select asserted.
// - Grant plus read returns captured input register.
// - Grant plus write loads outgoing data latch.
// - Chip reset clears registers, SCSI reset untouched.
// - Interrupt output raised on error or event.
// - Request only in DMA mode, register ready.
// - Request drops when grant is asserted.
// - DMA controller uses grant instead of select.
// - Block ready high when able, low until sent.
// - End of process terminates the DMA block.
// - Controller flags end with final byte.
// - Odd parity always generated; checking optional.
// - DB7 highest priority; arbitration parity invalid.
// - Register bits inverted versus active-low bus.
// - Eight locations, some differ read versus write.
// - Outgoing latch transparent, holds end-of-write value.
// - Software loads ID bits before arbitration.
// - Location 0 read shows live bus, parity checked.
// - Chip reset leaves every register zero.
// - DMA cycles ignore select lines, steer automatically.
module shp_device
  import shp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Processor and DMA port
  shp_if.dev hp,
  // SCSI data pins, active low, open drain
  input wire logic [7:0] scsi_db_n_i,
  input wire logic scsi_dbp_n_i,
  output logic [7:0] scsi_db_n_o,
  output logic [7:0] scsi_db_oe_o,
  output logic scsi_dbp_n_o,
  output logic scsi_dbp_oe_o,
  // SCSI byte sequencing and arbitration
  input wire logic scsi_byte_done_i,
  output logic scsi_byte_go_o,
  output logic arb_won_o
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic rst;
  logic rd_sel;
  logic wr_sel;
  logic dma_rd;
  logic dma_wr;
  logic rd_sel_q_r;
  logic dma_rd_q_r;
  logic dma_wr_q_r;
  logic rd_start;
  logic dma_wr_end;
  logic dma_rd_end;
  logic wr_first;
  logic wr_sel_q_r;

  assign rst = srst_i | ~hp.chip_reset_n;
  assign rd_sel = ~hp.cs_n & ~hp.rd_n;
  assign wr_sel = ~hp.cs_n & ~hp.wr_n;
  assign dma_rd = ~hp.dma_grant_strobe_n & ~hp.rd_n;
  assign dma_wr = ~hp.dma_grant_strobe_n & ~hp.wr_n;
  assign rd_start = rd_sel & ~rd_sel_q_r;
  assign wr_first = wr_sel & ~wr_sel_q_r;
  assign dma_wr_end = dma_wr_q_r & ~dma_wr;
  assign dma_rd_end = dma_rd_q_r & ~dma_rd;

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      rd_sel_q_r <= 1'b0;
      wr_sel_q_r <= 1'b0;
      dma_rd_q_r <= 1'b0;
      dma_wr_q_r <= 1'b0;
    end else begin
      rd_sel_q_r <= rd_sel;
      wr_sel_q_r <= wr_sel;
      dma_rd_q_r <= dma_rd;
      dma_wr_q_r <= dma_wr;
    end
  end

  // ----------------------------------------------------------------
  // SCSI pin synchroniser
  // ----------------------------------------------------------------
  logic [8:0] bus_s1_r;
  logic [8:0] bus_s2_r;
  logic [7:0] live_db;
  logic live_par;

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      bus_s1_r <= 9'h1ff;
      bus_s2_r <= 9'h1ff;
    end else begin
      bus_s1_r <= {scsi_dbp_n_i, scsi_db_n_i};
      bus_s2_r <= bus_s1_r;
    end
  end

  assign live_db = ~bus_s2_r[7:0];
  assign live_par = ~bus_s2_r[8];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] out_latch_r;
  logic [7:0] cmd_r;
  logic [7:0] mode_r;

  // Written every strobe cycle, so the latch follows the bus and keeps what was there last.
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      out_latch_r <= REG_RESET;
    end else if (dma_wr) begin
      out_latch_r <= hp.d_to_dev;
    end else if (wr_sel && hp.reg_select_lines == LOC_DATA) begin
      out_latch_r <= hp.d_to_dev;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      cmd_r <= REG_RESET;
      mode_r <= REG_RESET;
    end else if (wr_sel && hp.reg_select_lines == LOC_CMD) begin
      cmd_r <= hp.d_to_dev;
    end else if (wr_sel && hp.reg_select_lines == LOC_MODE) begin
      mode_r <= hp.d_to_dev;
    end
  end

  // ----------------------------------------------------------------
  // DMA engine
  // ----------------------------------------------------------------
  shp_dma_dir_type dma_dir_r;
  logic eop_done_r;
  logic out_full_r;
  logic in_full_r;
  logic [7:0] captured_in_r;
  logic dma_active;
  logic data_ready;
  logic eop_seen;
  logic recv_capture;

  assign dma_active = mode_r[MODE_DMA] & (dma_dir_r != DMA_OFF) & ~eop_done_r;
  assign eop_seen = (dma_rd | dma_wr) & ~hp.end_of_process_n & dma_active;
  assign recv_capture = scsi_byte_done_i & dma_active & (dma_dir_r == DMA_RECV);

  always_ff @(posedge core_clk_i) begin
    if (rst || !mode_r[MODE_DMA]) begin
      dma_dir_r <= DMA_OFF;
    end else if (wr_first && hp.reg_select_lines == LOC_SEND) begin
      dma_dir_r <= DMA_SEND;
    end else if (wr_first && (hp.reg_select_lines == LOC_TRECV || hp.reg_select_lines == LOC_IRECV)) begin
      dma_dir_r <= DMA_RECV;
    end
  end

  // Termination keeps the mode bit; only a fresh start command reopens the block.
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      eop_done_r <= 1'b0;
    end else if (eop_seen) begin
      eop_done_r <= 1'b1;
    end else if (wr_first && hp.reg_select_lines >= LOC_SEND) begin
      eop_done_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst || dma_dir_r != DMA_SEND) begin
      out_full_r <= 1'b0;
    end else if (dma_wr_end) begin
      out_full_r <= 1'b1;
    end else if (scsi_byte_done_i) begin
      out_full_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      captured_in_r <= REG_RESET;
    end else if (recv_capture) begin
      captured_in_r <= live_db;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst || dma_dir_r != DMA_RECV) begin
      in_full_r <= 1'b0;
    end else if (recv_capture) begin
      in_full_r <= 1'b1;
    end else if (dma_rd_end) begin
      in_full_r <= 1'b0;
    end
  end

  // The delayed strobe terms keep request and ready low in the gap cycle, before the full flags catch up.
  assign data_ready = dma_active & ((dma_dir_r == DMA_SEND) ? (~out_full_r & ~dma_wr_q_r) :
                                    (in_full_r & ~dma_rd_q_r));
  assign hp.dma_request = data_ready & ~mode_r[MODE_BLK] & hp.dma_grant_strobe_n;
  assign hp.ready = data_ready & mode_r[MODE_BLK];
  assign scsi_byte_go_o = out_full_r;

  // ----------------------------------------------------------------
  // Parity check and interrupt
  // ----------------------------------------------------------------
  logic par_err_r;
  logic eop_irq_r;
  logic par_bad;
  logic check_now;
  logic irq_clear;

  // Odd parity: the nine bits together hold an odd number of ones.
  assign par_bad = ~^{live_db, live_par};
  assign check_now = ((rd_start && hp.reg_select_lines == LOC_DATA) || recv_capture) &&
                     mode_r[MODE_PCHK] && !mode_r[MODE_ARB];
  assign irq_clear = rd_start && hp.reg_select_lines == LOC_CLEAR;

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      par_err_r <= 1'b0;
    end else if (check_now && par_bad) begin
      par_err_r <= 1'b1;
    end else if (irq_clear) begin
      par_err_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      eop_irq_r <= 1'b0;
    end else if (eop_seen && mode_r[MODE_EOPINT]) begin
      eop_irq_r <= 1'b1;
    end else if (irq_clear) begin
      eop_irq_r <= 1'b0;
    end
  end

  assign hp.intr = (par_err_r & mode_r[MODE_PINT]) | eop_irq_r;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_r;

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      rdata_r <= REG_RESET;
    end else if (dma_rd) begin
      rdata_r <= captured_in_r;
    end else if (rd_sel) begin
      if (hp.reg_select_lines == LOC_DATA) begin
        rdata_r <= live_db;
      end else if (hp.reg_select_lines == LOC_CMD) begin
        rdata_r <= cmd_r;
      end else if (hp.reg_select_lines == LOC_MODE) begin
        rdata_r <= mode_r;
      end else if (hp.reg_select_lines == LOC_STATUS) begin
        rdata_r <= {2'b00, in_full_r, out_full_r, eop_done_r, par_err_r, hp.intr, data_ready};
      end else if (hp.reg_select_lines == LOC_IN) begin
        rdata_r <= captured_in_r;
      end else begin
        rdata_r <= REG_RESET;
      end
    end
  end

  assign hp.d_from_dev = rdata_r;
  assign hp.d_from_dev_oe = rd_sel | dma_rd;

  // ----------------------------------------------------------------
  // SCSI drive and arbitration
  // ----------------------------------------------------------------
  // Returns the bits strictly above the lowest set bit of the ID.
  function automatic logic [7:0] above_mask(input logic [7:0] id);
    logic [7:0] m;
    logic seen;
    m = 8'h00;
    seen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      m[i] = seen;
      seen = seen | id[i];
    end
    return m;
  endfunction

  // Open drain: with the CMD_DBUS bit set, a one in the latch pulls the line low.
  assign scsi_db_n_o = 8'h00;
  assign scsi_db_oe_o = out_latch_r & {8{cmd_r[CMD_DBUS]}};
  assign scsi_dbp_n_o = 1'b0;
  assign scsi_dbp_oe_o = cmd_r[CMD_DBUS] & ~mode_r[MODE_ARB] & ~^out_latch_r;
  // The lowest set latch bit is the ID; DB7 outranks all others.
  assign arb_won_o = mode_r[MODE_ARB] & (|out_latch_r) & ((live_db & above_mask(out_latch_r)) == 8'h00);

endmodule

// *** core/shp_pkg.sv ***
package shp_pkg;

  // ----------------------------------------------------------------
  // Register locations
  // ----------------------------------------------------------------
  localparam logic [2:0] LOC_DATA = 3'h0;
  localparam logic [2:0] LOC_CMD = 3'h1;
  localparam logic [2:0] LOC_MODE = 3'h2;
  localparam logic [2:0] LOC_STATUS = 3'h5;
  localparam logic [2:0] LOC_SEND = 3'h5;
  localparam logic [2:0] LOC_TRECV = 3'h6;
  localparam logic [2:0] LOC_IN = 3'h6;
  localparam logic [2:0] LOC_IRECV = 3'h7;
  localparam logic [2:0] LOC_CLEAR = 3'h7;

  // ----------------------------------------------------------------
  // Field positions and reset value
  // ----------------------------------------------------------------
  localparam int CMD_DBUS = 0;
  localparam int MODE_ARB = 0;
  localparam int MODE_DMA = 1;
  localparam int MODE_EOPINT = 3;
  localparam int MODE_PINT = 4;
  localparam int MODE_PCHK = 5;
  localparam int MODE_BLK = 7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STROBE_MIN_PS = 12000;
  localparam int STROBE_CYC = (STROBE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYC - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum {DMA_OFF, DMA_SEND, DMA_RECV} shp_dma_dir_type;
  typedef enum {HST_IDLE, HST_STROBE, HST_GAP} shp_host_state_type;

endpackage

// *** core/shp_if.sv ***
`timescale 1ns/1ps
interface shp_if (
  input wire logic core_clk_i
);
  logic cs_n;
  logic [2:0] reg_select_lines;
  logic rd_n;
  logic wr_n;
  logic chip_reset_n;
  logic [7:0] d_to_dev;
  logic [7:0] d_from_dev;
  logic d_from_dev_oe;
  logic intr;
  logic dma_request;
  logic dma_grant_strobe_n;
  logic ready;
  logic end_of_process_n;

  modport dev (
    input cs_n, reg_select_lines, rd_n, wr_n, chip_reset_n, d_to_dev, dma_grant_strobe_n, end_of_process_n,
    output d_from_dev, d_from_dev_oe, intr, dma_request, ready
  );
  modport hst (
    output cs_n, reg_select_lines, rd_n, wr_n, chip_reset_n, d_to_dev, dma_grant_strobe_n, end_of_process_n,
    input d_from_dev, d_from_dev_oe, intr, dma_request, ready
  );
endinterface

// *** core/shp_host.sv ***
`timescale 1ns/1ps
module shp_host
  import shp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Device port
  shp_if.hst hp,
  // Command side
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_dma_i,
  input wire logic cmd_eop_i,
  input wire logic [2:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic chip_reset_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  // Device status mirrors
  output logic intr_o,
  output logic dma_request_o,
  output logic ready_o
);

  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  shp_host_state_type state_r;
  logic [1:0] cnt_r;
  logic write_r;
  logic dma_r;
  logic eop_r;
  logic [2:0] addr_r;
  logic [7:0] wdata_r;
  logic last;

  assign last = (state_r == HST_STROBE) && (cnt_r == STROBE_LAST);
  assign cmd_ready_o = (state_r == HST_IDLE);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r <= HST_IDLE;
      cnt_r <= 2'h0;
    end else begin
      case (state_r)
        HST_IDLE: begin
          cnt_r <= 2'h0;
          if (cmd_valid_i) begin
            state_r <= HST_STROBE;
          end
        end
        HST_STROBE: begin
          cnt_r <= cnt_r + 2'h1;
          if (last) begin
            state_r <= HST_GAP;
          end
        end
        default: begin
          state_r <= HST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      write_r <= 1'b0;
      dma_r <= 1'b0;
      eop_r <= 1'b0;
      addr_r <= 3'h0;
      wdata_r <= 8'h00;
    end else if (cmd_valid_i && state_r == HST_IDLE) begin
      write_r <= cmd_write_i;
      dma_r <= cmd_dma_i;
      eop_r <= cmd_eop_i;
      addr_r <= cmd_addr_i;
      wdata_r <= cmd_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
    end else begin
      rsp_valid_o <= last & ~write_r;
      if (last && !write_r) begin
        rsp_rdata_o <= hp.d_from_dev;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic strobe;

  assign strobe = (state_r == HST_STROBE);
  assign hp.cs_n = ~(strobe & ~dma_r);
  assign hp.dma_grant_strobe_n = ~(strobe & dma_r);
  assign hp.end_of_process_n = ~(strobe & dma_r & eop_r);
  assign hp.rd_n = ~(strobe & ~write_r);
  assign hp.wr_n = ~(strobe & write_r);
  assign hp.reg_select_lines = addr_r;
  assign hp.d_to_dev = wdata_r;
  assign hp.chip_reset_n = ~chip_reset_i;
  assign intr_o = hp.intr;
  assign dma_request_o = hp.dma_request;
  assign ready_o = hp.ready;

endmodule

// *** tb/shp_monitor.sv ***
`timescale 1ns/1ps
module shp_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Processor and DMA port
  input wire logic cs_n,
  input wire logic [2:0] reg_select_lines,
  input wire logic rd_n,
  input wire logic chip_reset_n,
  input wire logic d_from_dev_oe,
  input wire logic intr,
  input wire logic dma_request,
  input wire logic dma_grant_strobe_n,
  input wire logic ready,
  input wire logic end_of_process_n
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  // ----------------------------------------------------------------
  // Port behaviour
  // ----------------------------------------------------------------
  chk_oe_read_only: assert property (
    d_from_dev_oe == (!rd_n && (!cs_n || !dma_grant_strobe_n)))
    else $error("data bus drive does not match read cycle");
  chk_sel_stable: assert property (
    (!cs_n && !$past(cs_n)) |-> $stable(reg_select_lines))
    else $error("location changed during select");
  chk_req_grant_drop: assert property (
    !dma_grant_strobe_n |-> !dma_request)
    else $error("request high during grant");
  chk_req_ready_excl: assert property (
    !(dma_request && ready))
    else $error("request and ready together");
  chk_req_after_xfer: assert property (
    $rose(dma_grant_strobe_n) |-> (!dma_request)[*2])
    else $error("request high right after transfer");
  chk_ready_after_xfer: assert property (
    $rose(dma_grant_strobe_n) |-> (!ready)[*2])
    else $error("ready high right after transfer");
  // The start of a new block is at least two cycles away, so two quiet cycles are safe.
  chk_eop_halt: assert property (
    ($rose(dma_grant_strobe_n) && !$past(end_of_process_n)) |=> (!dma_request && !ready)[*2])
    else $error("transfers continue after end of process");
  chk_chip_reset: assert property (
    !chip_reset_n |=> (!intr && !dma_request && !ready))
    else $error("outputs not cleared by chip reset");
  chk_no_dual_sel: assert property (
    !(!cs_n && !dma_grant_strobe_n))
    else $error("select and grant together");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import shp_pkg::*;
  logic clk, srst, cmd_valid, cmd_write, cmd_dma, cmd_eop, chip_reset, byte_done, ext_p;
  logic cmd_ready, rsp_valid, intr, dreq, rdy, byte_go, arb_won, dbp_oe;
  logic [2:0] cmd_addr;
  logic [7:0] cmd_wdata, ext_db, rdv, rsp_rdata, db_oe;
  logic [2:0] locs [3] = '{3'h1, 3'h2, 3'h5};
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  shp_if hp_if (.core_clk_i(clk));
  // The bus is wired-or of both drivers, so reads see our own latch too.
  shp_device shp_device_i (.core_clk_i(clk), .srst_i(srst), .hp(hp_if.dev),
    .scsi_db_n_i(~(db_oe | ext_db)), .scsi_dbp_n_i(~(dbp_oe | ext_p)), .scsi_db_n_o(), .scsi_db_oe_o(db_oe),
    .scsi_dbp_n_o(), .scsi_dbp_oe_o(dbp_oe), .scsi_byte_done_i(byte_done), .scsi_byte_go_o(byte_go),
    .arb_won_o(arb_won));
  shp_host shp_host_i (.core_clk_i(clk), .srst_i(srst), .hp(hp_if.hst), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_dma_i(cmd_dma), .cmd_eop_i(cmd_eop), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .chip_reset_i(chip_reset), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata), .intr_o(intr), .dma_request_o(dreq), .ready_o(rdy));
  shp_monitor shp_monitor_i (.core_clk_i(clk), .srst_i(srst), .cs_n(hp_if.cs_n),
    .reg_select_lines(hp_if.reg_select_lines), .rd_n(hp_if.rd_n), .chip_reset_n(hp_if.chip_reset_n),
    .d_from_dev_oe(hp_if.d_from_dev_oe), .intr(hp_if.intr), .dma_request(hp_if.dma_request),
    .dma_grant_strobe_n(hp_if.dma_grant_strobe_n), .ready(hp_if.ready),
    .end_of_process_n(hp_if.end_of_process_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic d, input logic e, input logic [2:0] a, input logic [7:0] wd);
    int n;
    {cmd_write, cmd_dma, cmd_eop, cmd_addr, cmd_wdata} = {w, d, e, a, wd};
    rdv = 'x;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) rdv = rsp_rdata;
      n++;
    end
    if (n == 20) chk(1'b0, 1'b1, "command did not complete");
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic d, input logic [2:0] a, input logic [7:0] exp);
    acc(1'b0, d, 1'b0, a, 8'h00);
    chk(rdv, exp, "read data");
  endtask

  task automatic pulse();
    byte_done = 1'b1;
    @(negedge clk);
    byte_done = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {cmd_valid, cmd_write, cmd_dma, cmd_eop, chip_reset, byte_done, ext_p} = '0;
    cmd_addr = 3'h0;
    cmd_wdata = 8'h00;
    ext_db = 8'h00;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk(dreq, 1'b0, "request idle");
    foreach (locs[i]) rd(1'b0, locs[i], 8'h00);
    wr(3'h2, 8'h30);
    ext_db = 8'h3c;
    ext_p = 1'b1;
    repeat (4) @(negedge clk);
    rd(1'b0, 3'h0, 8'h3c);
    chk(intr, 1'b0, "good parity");
    ext_p = 1'b0;
    repeat (4) @(negedge clk);
    rd(1'b0, 3'h0, 8'h3c);
    chk(intr, 1'b1, "bad parity");
    rd(1'b0, 3'h7, 8'h00);
    chk(intr, 1'b0, "interrupt cleared");
    ext_db = 8'h00;
    wr(3'h2, 8'h00);
    rd(1'b0, 3'h3, 8'h00);
    wr(3'h0, 8'h06);
    wr(3'h1, 8'h01);
    chk(db_oe, 8'h06, "latch drive");
    chk(dbp_oe, 1'b1, "odd parity");
    rd(1'b0, 3'h0, 8'h06);
    wr(3'h0, 8'h04);
    wr(3'h2, 8'h01);
    repeat (3) @(negedge clk);
    chk(arb_won, 1'b1, "arbitration won");
    chk(dbp_oe, 1'b0, "parity off in arbitration");
    ext_db = 8'h80;
    repeat (4) @(negedge clk);
    chk(arb_won, 1'b0, "higher id wins");
    ext_db = 8'h00;
    wr(3'h2, 8'h02);
    wr(3'h5, 8'h00);
    chk(dreq, 1'b1, "send request");
    acc(1'b1, 1'b1, 1'b0, 3'h3, 8'ha5);
    chk(db_oe, 8'ha5, "dma write latch");
    chk(dreq, 1'b0, "latch full");
    chk(byte_go, 1'b1, "byte waiting");
    pulse();
    chk(dreq, 1'b1, "request after send");
    wr(3'h2, 8'h8a);
    wr(3'h5, 8'h00);
    chk(rdy, 1'b1, "block ready");
    chk(dreq, 1'b0, "no request in block mode");
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, 1'b1, k[0], 3'h0, 8'h3c);
      chk(rdy, 1'b0, "ready held low");
      pulse();
      chk(rdy, {7'h00, ~k[0]}, "ready after send");
    end
    chk(intr, 1'b1, "end of process interrupt");
    rd(1'b0, 3'h7, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h02);
    wr(3'h7, 8'h00);
    ext_db = 8'hc3;
    ext_p = 1'b1;
    repeat (4) @(negedge clk);
    pulse();
    chk(dreq, 1'b1, "receive request");
    rd(1'b1, 3'h5, 8'hc3);
    chk(dreq, 1'b0, "byte consumed");
    rd(1'b0, 3'h6, 8'hc3);
    chip_reset = 1'b1;
    repeat (3) @(negedge clk);
    chip_reset = 1'b0;
    repeat (4) @(negedge clk);
    rd(1'b0, 3'h2, 8'h00);
    chk(dreq, 1'b0, "request after reset");
    wrap_up();
  end
endmodule
